// >>> core/awc_consts.vh
// Constants for the converter control slice: offsets, fields, resets, timing.
// Assumes a Wishbone slave with 32-bit data and one register per aligned word.
`ifndef AWC_CONSTS_VH
`define AWC_CONSTS_VH

`define AWC_IDX_WINCTRL   4'h3
`define AWC_IDX_INTEN     4'h4
`define AWC_IDX_FLAGS     4'h5
`define AWC_IDX_STATUS    4'h6
`define AWC_IDX_DBG       4'h7
`define AWC_IDX_SAMPT     4'h8
`define AWC_IDX_RESULT    4'h9
`define AWC_IDX_SAMPLE    4'ha
`define AWC_IDX_LOWTH     4'hb
`define AWC_IDX_HIGHTH    4'hc
`define AWC_IDX_CFG       4'hd

`define AWC_WIN_SRC_BIT   3
`define AWC_MODE_NONE     3'h0
`define AWC_MODE_BELOW    3'h1
`define AWC_MODE_ABOVE    3'h2
`define AWC_MODE_INSIDE   3'h3
`define AWC_MODE_OUTSIDE  3'h4

`define AWC_F_TRIGGER_OVERRUN     5
`define AWC_F_SAMPLE_OVERWRITE     4
`define AWC_F_RESULT_OVERWRITE      3
`define AWC_F_WINMATCH    2
`define AWC_F_SAMPLE_READY     1
`define AWC_F_RESULT_READY      0

`define AWC_RST_REG8      8'h00
`define AWC_RST_REG16     16'h0000
`define AWC_CLK_DIV       8'h02
`define AWC_SETTLE_CYC    16'h0010
`define AWC_CONV_CYC      8'h0c

`endif

// >>> core/awc_ctrl.v
// Top of the converter control slice: Wishbone registers, flags, busy, debug.
// Assumes a classic Wishbone master on clk_i and synchronous sample and accumulator data; trigger, halt and accum-last pins are synchronised here.
`include "awc_consts.vh"
`default_nettype none
module awc_ctrl #(
  parameter [15:0] SETTLE_CYC = `AWC_SETTLE_CYC
) (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [5:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire        trigger_i,
  input  wire        dbg_halt_i,
  input  wire [15:0] sample_data_i,
  input  wire [15:0] accum_data_i,
  input  wire        accum_last_i,
  output reg         irq_o,
  output reg         busy_o,
  output reg         sampling_o
);
  // ---------------------------------------------------------------
  // Registers and state
  // ---------------------------------------------------------------
  localparam [3:0] ST_IDLE   = 4'b0001;
  localparam [3:0] ST_SAMPLE = 4'b0010;
  localparam [3:0] ST_CONV   = 4'b0100;
  localparam [3:0] ST_DONE   = 4'b1000;

  reg  [7:0]  winctrl_q;
  reg  [7:0]  inten_q;
  reg  [5:0]  flags_q;
  reg  [7:0]  dbg_q;
  reg  [7:0]  sampt_q;
  reg  [7:0]  cfg_q;
  reg  [15:0] low_q;
  reg  [15:0] high_q;
  reg  [15:0] result_q;
  reg  [15:0] sample_q;
  reg         res_unread_q;
  reg         smp_unread_q;
  reg  [3:0]  state_q;
  reg  [7:0]  div_q;
  reg  [7:0]  conv_q;
  reg  [15:0] settle_q;
  reg         cmp_pend_q;
  reg         cmp_wait_q;
  reg         accum_q;
  reg         trig_s1_q;
  reg         trig_s2_q;
  reg         trig_s3_q;
  reg         halt_s1_q;
  reg         halt_s2_q;
  reg         acc_s1_q;
  reg         acc_s2_q;

  wire        wb_req_w;
  wire        wr_w;
  wire        rd_w;
  wire [3:0]  idx_w;
  wire        half_en_w;
  wire        trig_w;
  wire        halted_w;
  wire        samp_done_w;
  wire        match_w;
  wire        conv_end_w;
  wire        cfg_wr_w;
  wire        start_w;
  reg  [5:0]  set_w;
  reg  [5:0]  clr_w;
  reg  [31:0] rdata_w;

  function hit;
    input [3:0] idx;
    input [3:0] want;
    begin
      hit = (idx == want);
    end
  endfunction

  assign wb_req_w = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_w     = wb_req_w && wb_we_i && wb_sel_i[0];
  assign rd_w     = wb_req_w && !wb_we_i;
  assign idx_w    = wb_adr_i[5:2];
  assign half_en_w = (div_q == 8'h00);
  assign trig_w   = trig_s2_q && !trig_s3_q;
  assign halted_w = halt_s2_q && !dbg_q[0];
  assign conv_end_w = (state_q == ST_DONE);
  assign cfg_wr_w = wr_w && (hit(idx_w, `AWC_IDX_SAMPT) || hit(idx_w, `AWC_IDX_CFG));
  assign start_w  = (state_q == ST_IDLE) && trig_w && !halted_w && (settle_q == 16'h0000);

  // ---------------------------------------------------------------
  // Input synchronisers and converter clock divider
  // ---------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      trig_s1_q <= 1'b0;
      trig_s2_q <= 1'b0;
      trig_s3_q <= 1'b0;
      halt_s1_q <= 1'b0;
      halt_s2_q <= 1'b0;
      acc_s1_q  <= 1'b0;
      acc_s2_q  <= 1'b0;
      div_q     <= 8'h00;
    end else begin
      trig_s1_q <= trigger_i;
      trig_s2_q <= trig_s1_q;
      trig_s3_q <= trig_s2_q;
      halt_s1_q <= dbg_halt_i;
      halt_s2_q <= halt_s1_q;
      acc_s1_q  <= accum_last_i;
      acc_s2_q  <= acc_s1_q;
      // A start restarts the converter clock so the sample phase has a fixed length.
      if (start_w) begin
        div_q <= 8'h00;
      end else begin
        div_q <= half_en_w ? (`AWC_CLK_DIV - 8'h01) : (div_q - 8'h01);
      end
    end
  end

  // ---------------------------------------------------------------
  // Sample timer and window comparator
  // ---------------------------------------------------------------
  awc_sample_timer u_timer (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .half_en_i  (half_en_w),
    .start_i    (start_w),
    .duration_i (sampt_q),
    .amp_en_i   (cfg_q[0]),
    .done_o     (samp_done_w)
  );

  awc_window_cmp u_cmp (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .src_sel_i (winctrl_q[`AWC_WIN_SRC_BIT]),
    .mode_i    (winctrl_q[2:0]),
    .result_i  (result_q),
    .sample_i  (sample_q),
    .low_i     (low_q),
    .high_i    (high_q),
    .match_o   (match_w)
  );

  // ---------------------------------------------------------------
  // Conversion sequence
  // ---------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_q  <= ST_IDLE;
      conv_q   <= 8'h00;
      settle_q <= 16'h0000;
      accum_q  <= 1'b0;
    end else begin
      if (cfg_wr_w) begin
        settle_q <= SETTLE_CYC;
      end else if (settle_q != 16'h0000) begin
        settle_q <= settle_q - 16'h0001;
      end
      case (state_q)
        ST_IDLE: begin
          // A halted device takes no new trigger unless DBG bit 0 is set; the current one always ends first.
          if (start_w) begin
            state_q <= ST_SAMPLE;
          end
        end
        ST_SAMPLE: begin
          if (samp_done_w) begin
            state_q <= ST_CONV;
            conv_q  <= `AWC_CONV_CYC;
          end
        end
        ST_CONV: begin
          if (half_en_w) begin
            if (conv_q == 8'h01) begin
              state_q <= ST_DONE;
              accum_q <= acc_s2_q;
            end
            conv_q <= conv_q - 8'h01;
          end
        end
        ST_DONE: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Flag set and clear; a set in the same cycle wins
  // ---------------------------------------------------------------
  always @* begin
    set_w = 6'h00;
    clr_w = 6'h00;
    set_w[`AWC_F_TRIGGER_OVERRUN]  = trig_w && (state_q != ST_IDLE);
    set_w[`AWC_F_SAMPLE_OVERWRITE]  = conv_end_w && smp_unread_q;
    set_w[`AWC_F_RESULT_OVERWRITE]   = conv_end_w && accum_q && res_unread_q;
    set_w[`AWC_F_WINMATCH] = cmp_wait_q && match_w;
    set_w[`AWC_F_SAMPLE_READY]  = conv_end_w;
    set_w[`AWC_F_RESULT_READY]   = conv_end_w && accum_q;
    if (wr_w && hit(idx_w, `AWC_IDX_FLAGS)) begin
      clr_w = wb_dat_i[5:0];
    end
    clr_w[`AWC_F_SAMPLE_READY] = clr_w[`AWC_F_SAMPLE_READY] || (rd_w && hit(idx_w, `AWC_IDX_SAMPLE));
    clr_w[`AWC_F_RESULT_READY]  = clr_w[`AWC_F_RESULT_READY] || (rd_w && hit(idx_w, `AWC_IDX_RESULT));
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      flags_q      <= 6'h00;
      sample_q     <= `AWC_RST_REG16;
      result_q     <= `AWC_RST_REG16;
      smp_unread_q <= 1'b0;
      res_unread_q <= 1'b0;
      cmp_pend_q   <= 1'b0;
      cmp_wait_q   <= 1'b0;
      irq_o        <= 1'b0;
      busy_o       <= 1'b0;
      sampling_o   <= 1'b0;
    end else begin
      flags_q <= (flags_q & ~clr_w) | set_w;
      // The comparator sees the new value one cycle after capture and answers one later.
      cmp_pend_q <= conv_end_w;
      cmp_wait_q <= cmp_pend_q;
      if (conv_end_w) begin
        sample_q     <= sample_data_i;
        smp_unread_q <= 1'b1;
        if (accum_q) begin
          result_q     <= accum_data_i;
          res_unread_q <= 1'b1;
        end
      end else begin
        if (rd_w && hit(idx_w, `AWC_IDX_SAMPLE)) begin
          smp_unread_q <= 1'b0;
        end
        if (rd_w && hit(idx_w, `AWC_IDX_RESULT)) begin
          res_unread_q <= 1'b0;
        end
      end
      irq_o      <= |(((flags_q & ~clr_w) | set_w) & inten_q[5:0]);
      busy_o     <= (state_q != ST_IDLE) || (settle_q != 16'h0000) || cfg_wr_w;
      sampling_o <= (state_q == ST_SAMPLE);
    end
  end

  // ---------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      winctrl_q <= `AWC_RST_REG8;
      inten_q   <= `AWC_RST_REG8;
      dbg_q     <= `AWC_RST_REG8;
      sampt_q   <= `AWC_RST_REG8;
      cfg_q     <= `AWC_RST_REG8;
      low_q     <= `AWC_RST_REG16;
      high_q    <= `AWC_RST_REG16;
    end else if (wb_req_w && wb_we_i) begin
      if (wb_sel_i[0]) begin
        if (hit(idx_w, `AWC_IDX_WINCTRL)) winctrl_q <= {4'h0, wb_dat_i[3:0]};
        if (hit(idx_w, `AWC_IDX_INTEN))   inten_q   <= {2'h0, wb_dat_i[5:0]};
        if (hit(idx_w, `AWC_IDX_DBG))     dbg_q     <= {7'h00, wb_dat_i[0]};
        if (hit(idx_w, `AWC_IDX_SAMPT))   sampt_q   <= wb_dat_i[7:0];
        if (hit(idx_w, `AWC_IDX_CFG))     cfg_q     <= {7'h00, wb_dat_i[0]};
        if (hit(idx_w, `AWC_IDX_LOWTH))   low_q[7:0]  <= wb_dat_i[7:0];
        if (hit(idx_w, `AWC_IDX_HIGHTH))  high_q[7:0] <= wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        if (hit(idx_w, `AWC_IDX_LOWTH))   low_q[15:8]  <= wb_dat_i[15:8];
        if (hit(idx_w, `AWC_IDX_HIGHTH))  high_q[15:8] <= wb_dat_i[15:8];
      end
    end
  end

  // ---------------------------------------------------------------
  // Read mux and acknowledge
  // ---------------------------------------------------------------
  always @* begin
    case (idx_w)
      `AWC_IDX_WINCTRL: rdata_w = {24'h000000, winctrl_q};
      `AWC_IDX_INTEN:   rdata_w = {24'h000000, inten_q};
      `AWC_IDX_FLAGS:   rdata_w = {26'h0, flags_q};
      `AWC_IDX_STATUS:  rdata_w = {31'h0, busy_o};
      `AWC_IDX_DBG:     rdata_w = {24'h000000, dbg_q};
      `AWC_IDX_SAMPT:   rdata_w = {24'h000000, sampt_q};
      `AWC_IDX_RESULT:  rdata_w = {16'h0000, result_q};
      `AWC_IDX_SAMPLE:  rdata_w = {16'h0000, sample_q};
      `AWC_IDX_LOWTH:   rdata_w = {16'h0000, low_q};
      `AWC_IDX_HIGHTH:  rdata_w = {16'h0000, high_q};
      `AWC_IDX_CFG:     rdata_w = {24'h000000, cfg_q};
      default:          rdata_w = 32'h00000000;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_req_w;
      wb_dat_o <= wb_req_w ? rdata_w : 32'h00000000;
    end
  end
endmodule // awc_ctrl
`default_nettype wire

// >>> core/awc_sample_timer.v
// Sample-phase timer counting half converter cycles.
// Assumes a one-cycle half-period enable from the main divider.
`default_nettype none
module awc_sample_timer (
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire       half_en_i,
  input  wire       start_i,
  input  wire [7:0] duration_i,
  input  wire       amp_en_i,
  output reg        done_o
);
  reg  [9:0] cnt_q;
  reg        run_q;
  wire [9:0] target_w;

  // Half cycles: 2*dur+1 without amplifier, 2*dur+2 with it.
  assign target_w = {1'b0, duration_i, 1'b0} + (amp_en_i ? 10'h002 : 10'h001);

  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q  <= 10'h000;
      run_q  <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i) begin
        cnt_q <= 10'h000;
        run_q <= 1'b1;
      end else if (run_q && half_en_i) begin
        if (cnt_q + 10'h001 >= target_w) begin
          run_q  <= 1'b0;
          done_o <= 1'b1;
        end
        cnt_q <= cnt_q + 10'h001;
      end
    end
  end
endmodule // awc_sample_timer
`default_nettype wire

// >>> core/awc_window_cmp.v
// Window comparator for the converter control slice.
// Assumes registered inputs from the main module on the same clock.
`default_nettype none
module awc_window_cmp (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        src_sel_i,
  input  wire [2:0]  mode_i,
  input  wire [15:0] result_i,
  input  wire [15:0] sample_i,
  input  wire [15:0] low_i,
  input  wire [15:0] high_i,
  output reg         match_o
);
`include "awc_consts.vh"
  wire [15:0] value_w;
  wire        below_w;
  wire        above_w;
  reg         match_d;

  assign value_w = src_sel_i ? sample_i : result_i;
  assign below_w = value_w < low_i;
  assign above_w = value_w > high_i;

  always @* begin
    case (mode_i)
      `AWC_MODE_BELOW:   match_d = below_w;
      `AWC_MODE_ABOVE:   match_d = above_w;
      `AWC_MODE_INSIDE:  match_d = (value_w > low_i) && (value_w < high_i);
      `AWC_MODE_OUTSIDE: match_d = below_w || above_w;
      default:           match_d = 1'b0;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      match_o <= 1'b0;
    end else begin
      match_o <= match_d;
    end
  end
endmodule // awc_window_cmp
`default_nettype wire

// >>> dv/awc_ctrl_properties.sv
// Concurrent checks on the ports of the converter control slice.
// Assumes one clock clk_i and a synchronous active-high reset rst_i.
`default_nettype none
module awc_ctrl_props (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [5:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        irq_o,
  input wire logic        busy_o,
  input wire logic        sampling_o
);
  // ----------------------------------------
  // Helpers and properties.
  // ----------------------------------------
  wire [3:0] idx    = wb_adr_i[5:2];
  wire       rd_ack = wb_ack_o && !wb_we_i;
  wire       wr_ack = wb_ack_o && wb_we_i && wb_sel_i[0];
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  idle_data_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data not zero without ack");
  unmapped_read_a: assert property (rd_ack && (idx < 4'h3 || idx > 4'hd) |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  flag_width_a: assert property (rd_ack && (idx == 4'h4 || idx == 4'h5) |-> wb_dat_o[31:6] == 26'h0)
    else $error("unused enable or flag bits set");
  busy_sampling_a: assert property (sampling_o && $past(sampling_o) |-> busy_o)
    else $error("busy low during sample phase");
  busy_convert_a: assert property ($fell(sampling_o) |-> busy_o [*8])
    else $error("busy dropped during conversion");
  settle_busy_a: assert property (wr_ack && idx == 4'h8 |-> ##[1:3] busy_o)
    else $error("busy not raised for settling");
  irq_masked_a: assert property (wr_ack && idx == 4'h4 && wb_dat_i[5:0] == 6'h0 |-> ##2 !irq_o)
    else $error("irq high with all enables off");
  cover property ($fell(busy_o));
  cover property ($rose(irq_o));
  cover property (rd_ack && idx == 4'h5);
endmodule // awc_ctrl_props

bind awc_ctrl awc_ctrl_props u_props (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o),
  .busy_o(busy_o), .sampling_o(sampling_o));
`default_nettype wire

// >>> dv/testbench.sv
// Self-checking bench for the converter control slice.
// Assumes awc_ctrl with a classic Wishbone slave and the bound checker.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, trg = 0, halt = 0, al = 1;
  logic [5:0]  adr = 0;
  logic [3:0]  sel = 0;
  logic [31:0] dat = 0;
  logic [15:0] smp = 0, acc = 0, s, a;
  logic [15:0] tb[5] = '{16'h0fff, 16'h1000, 16'h1800, 16'h2000, 16'h2001};
  logic [7:0]  r8;
  logic [2:0]  md;
  logic        sr, w;
  wire  [31:0] rdat;
  wire         ack, irq, busy, smpl;
  integer      seed = 32'h6acd5403, miscompares = 0, samples_checked = 0, cyc_n = 0, scnt = 0;
  logic [31:0] eq[$], mq[$];
  always #2 clk_i = ~clk_i;
  awc_ctrl #(.SETTLE_CYC(16'h0004)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .trigger_i(trg), .dbg_halt_i(halt),
    .sample_data_i(smp), .accum_data_i(acc), .accum_last_i(al), .irq_o(irq),
    .busy_o(busy), .sampling_o(smpl));
  // ----------------------------------------
  // Checking, bus and conversion tasks.
  // ----------------------------------------
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  always @(posedge clk_i) begin
    cyc_n++;
    if (smpl === 1'b1) scnt++;
    if (ack === 1'b1 && !we) begin
      chk(rdat & mq[0], eq[0] & mq[0]);
      void'(mq.pop_front());
      void'(eq.pop_front());
    end
    if (cyc_n == 60000) begin
      miscompares++;
      wrap_up();
    end
  end
  task automatic bus(input logic wr_en, input logic [3:0] i, input logic [31:0] d, e, m);
    @(posedge clk_i);
    cyc <= 1;
    stb <= 1;
    we  <= wr_en;
    adr <= {i, 2'b00};
    dat <= d;
    sel <= 4'h3;
    if (!wr_en) begin
      eq.push_back(e);
      mq.push_back(m);
    end
    do @(posedge clk_i); while (ack !== 1'b1);
    cyc <= 0;
    stb <= 0;
    we  <= 0;
  endtask
  task automatic wr(input logic [3:0] i, input logic [31:0] d);
    bus(1, i, d, 0, 0);
  endtask
  task automatic rd(input logic [3:0] i, input logic [31:0] e, m);
    bus(0, i, 0, e, m);
  endtask
  task automatic idle;
    while (busy !== 1'b0) @(posedge clk_i);
  endtask
  task automatic pulse;
    trg <= 1;
    repeat (4) @(posedge clk_i);
    trg <= 0;
  endtask
  task automatic conv;
    repeat (4) @(posedge clk_i);
    idle;
    scnt = 0;
    pulse;
    repeat (8) @(posedge clk_i);
    idle;
    repeat (3) @(posedge clk_i);
  endtask
  function automatic logic wm(input logic [2:0] m, input logic [15:0] o, l, h);
    case (m)
      3'h1: wm = o < l;
      3'h2: wm = o > h;
      3'h3: wm = o > l && o < h;
      3'h4: wm = o < l || o > h;
      default: wm = 1'b0;
    endcase
  endfunction
  // ----------------------------------------
  // Main sequence.
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 0;
    for (int i = 3; i < 9; i++) rd(i[3:0], 0, 32'hff);
    wr(0, '1);
    rd(0, 0, '1);
    rd(15, 0, '1);
    wr(3, '1);
    rd(3, 8'h0f, 8'hff);
    wr(4, '1);
    rd(4, 8'h3f, 8'hff);
    wr(6, '1);
    rd(6, 0, 8'hff);
    r8 = $random(seed);
    wr(8, r8);
    rd(6, 1, 8'hff);
    rd(8, r8, 8'hff);
    wr(4, 8'h04);
    wr(8, 2);
    wr(11, 16'h1000);
    wr(12, 16'h2000);
    rd(11, 16'h1000, 16'hffff);
    rd(12, 16'h2000, 16'hffff);
    for (int i = 0; i < 12; i++) begin
      md = i % 6;
      sr = $random(seed);
      s = tb[$unsigned($random(seed)) % 5];
      a = tb[$unsigned($random(seed)) % 5];
      smp <= s;
      acc <= a;
      w = wm(md, sr ? s : a, 16'h1000, 16'h2000);
      wr(3, {sr, md});
      conv;
      chk(irq, w);
      rd(6, 0, 8'hff);
      rd(5, {w, 2'b11}, 8'h3f);
      rd(10, s, 16'hffff);
      rd(9, a, 16'hffff);
      rd(5, {w, 2'b00}, 8'h3f);
      wr(5, 8'h3f);
      rd(5, 0, 8'h3f);
      chk(irq, 0);
    end
    wr(3, 0);
    al <= 0;
    conv;
    conv;
    rd(5, 8'h12, 8'h3f);
    al <= 1;
    conv;
    rd(5, 8'h13, 8'h3f);
    conv;
    rd(5, 8'h1b, 8'h3f);
    pulse;
    while (smpl !== 1'b1) @(posedge clk_i);
    repeat (2) @(posedge clk_i);
    pulse;
    idle;
    repeat (3) @(posedge clk_i);
    rd(5, 8'h3b, 8'h3f);
    wr(5, 0);
    rd(5, 8'h3b, 8'h3f);
    rd(10, smp, 16'hffff);
    rd(9, acc, 16'hffff);
    wr(5, 8'h3f);
    wr(7, 0);
    halt <= 1;
    repeat (4) @(posedge clk_i);
    pulse;
    repeat (40) @(posedge clk_i);
    chk(busy, 0);
    rd(5, 0, 8'h3f);
    wr(7, 1);
    conv;
    rd(5, 8'h03, 8'h3f);
    halt <= 0;
    wr(4, 8'h3f);
    @(posedge clk_i);
    chk(irq, 1);
    wr(4, 0);
    @(posedge clk_i);
    chk(irq, 0);
    for (int p = 0; p < 4; p++) begin
      wr(13, p[1]);
      wr(8, p[0] ? 8'h03 : 8'h00);
      conv;
      chk(scnt, (2 * (p[0] ? 3 : 0) + 1 + p[1]) * 2);
    end
    wrap_up;
  end
endmodule // testbench
`default_nettype wire
